// ---- hw/bridge_link_cfg.v ----
/*
  Configuration registers of the bridge function facing the upstream hub
  link, plus per-slot IDSEL concealment and LAN function decode masking.
  Assumes a configuration access port from the bridge's own decoder on the
  same clock, and a partner rate capability level arriving on pins.
*/
`default_nettype none
`include "bridge_link_defs.vh"

module bridge_link_cfg #(
    parameter SLOT_COUNT = 6
) (
    input  wire                   clock,
    input  wire                   arst_n,
    // configuration access port
    input  wire                   cfg_wr,
    input  wire                   cfg_rd,
    input  wire [7:0]             cfg_addr,
    input  wire [3:0]             cfg_be,
    input  wire [31:0]            cfg_wdata,
    output reg  [31:0]            cfg_rdata,
    output reg                    cfg_rvalid,
    // parity control
    input  wire                   parity_err_response,
    output reg                    link_parity_check_en,
    // link arbitration
    input  wire                   link_msg_end,
    input  wire                   link_other_req,
    output wire                   link_yield,
    // partner capability pins, asynchronous
    input  wire [2:0]             partner_rate_pins,
    output reg                    link_rate_captured,
    // configuration cycle concealment
    input  wire                   pci_cfg_cycle,
    input  wire [SLOT_COUNT-1:0]  slot_idsel_raw,
    output reg  [SLOT_COUNT-1:0]  slot_idsel,
    input  wire                   lan_cfg_decode,
    output reg                    lan_cfg_select
);

    localparam ST_WAIT   = 4'b0001;
    localparam ST_FILL   = 4'b0010;
    localparam ST_SETTLE = 4'b0100;
    localparam ST_DONE   = 4'b1000;

    reg  [2:0]             rate_sync1_reg;
    reg  [2:0]             rate_sync2_reg;
    reg  [3:0]             cap_state_reg;
    reg  [3:0]             cap_state_next;
    reg  [2:0]             link_rate_code_reg;
    reg                    link_parity_override_reg;
    reg  [3:0]             link_arbiter_slice_reg;
    reg  [SLOT_COUNT-1:0]  slot_conceal_reg;
    reg                    lan_function_conceal_reg;
    reg  [31:0]            link_cmd_view;
    reg  [31:0]            conceal_view;
    reg  [31:0]            rdata_next;
    wire                   hit_link_cmd;
    wire                   hit_conceal;
    wire [1:0]             link_width_code;
    wire                   link_rate_valid;
    wire [2:0]             max_burst_code;

    // exact dword match; any other offset reads zero and takes no write
    assign hit_link_cmd    = (cfg_addr == `LINK_CMD_OFFSET);
    assign hit_conceal     = (cfg_addr == `CONCEAL_OFFSET);
    assign link_width_code = `WIDTH_CODE_8BIT;
    assign link_rate_valid = `RATE_VALID_VALUE;
    // the link always moves 64-byte bursts, so the code is fixed
    assign max_burst_code  = `MAX_BURST_64B;

    // partner rate pins cross in through two flops before anything reads them
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rate_sync1_reg <= 3'h0;
            rate_sync2_reg <= 3'h0;
        end else begin
            rate_sync1_reg <= partner_rate_pins;
            rate_sync2_reg <= rate_sync1_reg;
        end
    end

    // capture once after release; the first two edges only fill the synchroniser
    // limitation: the pins must hold their level until the capture edge
    always @* begin
        case (cap_state_reg)
            ST_WAIT:   cap_state_next = ST_FILL;
            ST_FILL:   cap_state_next = ST_SETTLE;
            ST_SETTLE: cap_state_next = ST_DONE;
            ST_DONE:   cap_state_next = ST_DONE;
            default:   cap_state_next = ST_WAIT;
        endcase
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cap_state_reg      <= ST_WAIT;
            link_rate_code_reg <= `RATE_CODE_4X;
            link_rate_captured <= 1'b0;
        end else begin
            cap_state_reg <= cap_state_next;
            if (cap_state_reg == ST_SETTLE) begin
                link_rate_code_reg <= rate_sync2_reg;
                link_rate_captured <= 1'b1;
            end
        end
    end

    // register writes; only defined writable bits take data
    // a read in the same cycle as a write still returns the old contents
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            link_parity_override_reg <= `PARITY_OVR_RESET;
            link_arbiter_slice_reg   <= `SLICE_RESET;
            slot_conceal_reg         <= {SLOT_COUNT{1'b0}};
            lan_function_conceal_reg <= 1'b0;
        end else if (cfg_wr) begin
            if (hit_link_cmd && cfg_be[`SLICE_BYTE]) begin
                link_parity_override_reg <= cfg_wdata[`PARITY_OVR_BIT];
                link_arbiter_slice_reg   <= cfg_wdata[`SLICE_MSB:`SLICE_LSB];
            end
            if (hit_conceal && cfg_be[`SLOT_BYTE])
                slot_conceal_reg <= cfg_wdata[SLOT_COUNT-1:0];
            if (hit_conceal && cfg_be[`LAN_BYTE])
                lan_function_conceal_reg <= cfg_wdata[`LAN_CONCEAL_BIT];
        end
    end

    // read views; reserved positions come from constants, never from flops
    always @* begin
        link_cmd_view = {`RSVD_HI_VALUE,
                         link_parity_override_reg,
                         link_arbiter_slice_reg,
                         link_width_code,
                         link_rate_valid,
                         link_rate_code_reg,
                         `RSVD_MID_VALUE,
                         max_burst_code,
                         `RSVD_LOW_VALUE};
        conceal_view = 32'h0000_0000;
        conceal_view[SLOT_COUNT-1:0]   = slot_conceal_reg;
        conceal_view[`LAN_CONCEAL_BIT] = lan_function_conceal_reg;
        if (hit_link_cmd)
            rdata_next = link_cmd_view;
        else if (hit_conceal)
            rdata_next = conceal_view;
        else
            rdata_next = 32'h0000_0000;
    end

    // data holds until the next read, so a slow consumer may take it late
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cfg_rdata  <= 32'h0000_0000;
            cfg_rvalid <= 1'b0;
        end else begin
            cfg_rvalid <= cfg_rd;
            if (cfg_rd)
                cfg_rdata <= rdata_next;
        end
    end

    // override wins over the parity error response enable
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            link_parity_check_en <= 1'b0;
        else
            link_parity_check_en <= parity_err_response & ~link_parity_override_reg;
    end

    link_slice_timer #(
        .CNT_W (`SLICE_COUNT_W)
    ) u_slice (
        .clock              (clock),
        .arst_n             (arst_n),
        .link_arbiter_slice (link_arbiter_slice_reg),
        .msg_end            (link_msg_end),
        .other_req          (link_other_req),
        .yield_pulse        (link_yield)
    );

    // per slot: bit n gates the line for AD16+n during configuration cycles
    // changing a bit inside a cycle cuts the line mid-cycle, hence hide at init only
    genvar s;
    generate
        for (s = 0; s < SLOT_COUNT; s = s + 1) begin : g_slot
            always @(posedge clock or negedge arst_n) begin
                if (!arst_n)
                    slot_idsel[s] <= 1'b0;
                else if (pci_cfg_cycle && slot_conceal_reg[s])
                    slot_idsel[s] <= 1'b0;
                else
                    slot_idsel[s] <= pci_cfg_cycle & slot_idsel_raw[s];
            end
        end
    endgenerate

    // the LAN hide only masks the internal decode; its bus line is not touched
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n)
            lan_cfg_select <= 1'b0;
        else
            lan_cfg_select <= lan_cfg_decode & ~lan_function_conceal_reg;
    end

endmodule

`default_nettype wire

// ---- hw/bridge_link_defs.vh ----
/*
  Named offsets, field positions, reset values and fixed codes for the
  bridge link configuration and secondary device concealment registers.
  Assumes it is included by bare name from the design files of this block.
*/
`ifndef BRIDGE_LINK_DEFS_VH
`define BRIDGE_LINK_DEFS_VH

// configuration offsets (byte addresses, dword aligned)
`define LINK_CMD_OFFSET      8'h40
`define CONCEAL_OFFSET       8'h44

// link command control field positions
`define PARITY_OVR_BIT       20
`define SLICE_MSB            19
`define SLICE_LSB            16
`define SLICE_BYTE           2
`define RSVD_HI_MSB          31
`define RSVD_HI_LSB          21

// link command control fixed and reset values
`define LINK_CMD_RESET       32'h7620_2802
`define RSVD_HI_VALUE        11'h3b1
`define WIDTH_CODE_8BIT      2'h0
`define RATE_VALID_VALUE     1'b1
`define RATE_CODE_4X         3'h2
`define MAX_BURST_64B        3'h1
`define RSVD_MID_VALUE       6'h00
`define RSVD_LOW_VALUE       1'b0
`define SLICE_RESET          4'h0
`define PARITY_OVR_RESET     1'b0

// concealment register
`define CONCEAL_RESET        16'h0000
`define LAN_CONCEAL_BIT      8
`define SLOT_BYTE            0
`define LAN_BYTE             1

// arbiter slice granularity: each code step is four base clocks
`define SLICE_UNIT_SHIFT     2'h2
`define SLICE_COUNT_W        6

`endif

// ---- hw/link_slice_timer.v ----
/*
  Hub link arbiter time slice timer: counts base clocks of ownership and
  asks the link to yield to the other master at a message boundary.
  Assumes msg_end and other_req come from link logic on the same clock.
*/
`default_nettype none
`include "bridge_link_defs.vh"

module link_slice_timer #(
    parameter CNT_W = `SLICE_COUNT_W
) (
    input  wire             clock,
    input  wire             arst_n,
    input  wire [3:0]       link_arbiter_slice,
    input  wire             msg_end,
    input  wire             other_req,
    output reg              yield_pulse
);

    reg  [CNT_W-1:0] owned_reg;
    reg  [CNT_W-1:0] owned_next;
    reg  [CNT_W-1:0] slice_len;
    wire             expired;
    wire             yield_next;

    // slice code in units of four base clocks; CNT_W must cover the widest slice
    always @* begin
        slice_len = {CNT_W{1'b0}};
        slice_len[`SLICE_UNIT_SHIFT +: (`SLICE_MSB-`SLICE_LSB+1)] = link_arbiter_slice;
    end
    // a zero slice is expired at once, so every message may hand over
    assign expired    = (owned_reg >= slice_len);
    assign yield_next = msg_end & other_req & expired;

    always @* begin
        owned_next = owned_reg;
        if (yield_next)
            owned_next = {CNT_W{1'b0}};
        else if (owned_reg != {CNT_W{1'b1}})
            owned_next = owned_reg + {{(CNT_W-1){1'b0}}, 1'b1};
    end

    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            owned_reg   <= {CNT_W{1'b0}};
            yield_pulse <= 1'b0;
        end else begin
            owned_reg   <= owned_next;
            yield_pulse <= yield_next;
        end
    end

endmodule

`default_nettype wire

// ---- verif/bridge_link_cfg_asserts.sv ----
/* port checker for the bridge link configuration block.
   assumes it is bound to the top module on its ports. */
`default_nettype none
module bridge_link_cfg_asserts #(parameter SLOT_COUNT = 6) (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [7:0] cfg_addr,
    input wire logic [3:0] cfg_be,
    input wire logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata,
    input wire logic cfg_rvalid,
    input wire logic parity_err_response,
    input wire logic link_parity_check_en,
    input wire logic link_msg_end,
    input wire logic link_other_req,
    input wire logic link_yield,
    input wire logic [2:0] partner_rate_pins,
    input wire logic link_rate_captured,
    input wire logic pci_cfg_cycle,
    input wire logic [SLOT_COUNT-1:0] slot_idsel_raw,
    input wire logic [SLOT_COUNT-1:0] slot_idsel,
    input wire logic lan_cfg_decode,
    input wire logic lan_cfg_select
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!arst_n);
    logic ovr, lan;
    logic [3:0] slc;
    logic [SLOT_COUNT-1:0] hid;
    wire w40 = cfg_wr && cfg_addr == 8'h40;
    wire w44 = cfg_wr && cfg_addr == 8'h44;
    // shadow of the writable fields, so outputs can be tied to them
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            {ovr, slc} <= 5'h00;
            {lan, hid} <= '0;
        end else begin
            if (w40 && cfg_be[2]) {ovr, slc} <= cfg_wdata[20:16];
            if (w44 && cfg_be[0]) hid <= cfg_wdata[SLOT_COUNT-1:0];
            if (w44 && cfg_be[1]) lan <= cfg_wdata[8];
        end
    end
    property p_par;
        $past(arst_n) |-> link_parity_check_en == $past(parity_err_response && !ovr);
    endproperty
    a_par: assert property (p_par) else $error("parity check enable wrong");
    property p_early;
        link_yield && slc != 4'h0 |=> !link_yield [*4];
    endproperty
    a_early: assert property (p_early) else $error("yield before slice expired");
    property p_slice0;
        slc == 4'h0 && link_msg_end && link_other_req |=> link_yield;
    endproperty
    a_slice0: assert property (p_slice0) else $error("no yield with zero slice");
    property p_yield;
        link_yield |-> $past(link_msg_end && link_other_req);
    endproperty
    a_yield: assert property (p_yield) else $error("yield without cause");
    property p_fixed;
        cfg_rd && cfg_addr == 8'h40 |=> cfg_rvalid
            && cfg_rdata == {11'h3b1, $past({ovr, slc}), 3'h1, cfg_rdata[12:10], 10'h002};
    endproperty
    a_fixed: assert property (p_fixed) else $error("link command read wrong");
    property p_rate;
        cfg_rd && cfg_addr == 8'h40 && link_rate_captured |=> cfg_rdata[12:10] == 3'h2;
    endproperty
    a_rate: assert property (p_rate) else $error("rate code wrong");
    property p_idsel;
        $past(arst_n) |->
            slot_idsel == $past(slot_idsel_raw & ~hid & {SLOT_COUNT{pci_cfg_cycle}});
    endproperty
    a_idsel: assert property (p_idsel) else $error("slot select wrong");
    property p_lan;
        $past(arst_n) |-> lan_cfg_select == $past(lan_cfg_decode && !lan);
    endproperty
    a_lan: assert property (p_lan) else $error("lan decode mask wrong");
    property p_unm;
        cfg_rd && cfg_addr != 8'h40 && cfg_addr != 8'h44 |=> cfg_rvalid && cfg_rdata == 0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    c_yield: cover property (link_yield);
    c_hide: cover property (pci_cfg_cycle && |hid);
    c_unm: cover property (cfg_rd && cfg_addr == 8'h48);
endmodule
`default_nettype wire

// ---- verif/bridge_link_cfg_tb.sv ----
/* self-checking bench for the bridge link configuration block.
   assumes hub_partner and the checker are compiled before it. */
`default_nettype none
module bridge_link_cfg_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0, arst_n = 1'b0, cfg_wr = 1'b0, cfg_rd = 1'b0, want = 1'b1;
    logic parity_err_response = 1'b1, pci_cfg_cycle = 1'b0, lan_cfg_decode = 1'b1;
    logic [3:0] gap = 4'h0, cfg_be = 4'h0;
    logic [7:0] cfg_addr = 8'h00;
    logic [31:0] cfg_wdata = 32'h0000_0000, cfg_rdata;
    logic [5:0] slot_idsel_raw = 6'h3f, slot_idsel;
    logic cfg_rvalid, link_parity_check_en, link_msg_end, link_other_req, link_yield;
    logic link_rate_captured, lan_cfg_select;
    logic [2:0] partner_rate_pins;
    int fails = 0, tests_run = 0, cycles = 0;
    initial forever #20 clock = ~clock;
    bridge_link_cfg #(.SLOT_COUNT(6)) dut (.clock, .arst_n, .cfg_wr, .cfg_rd, .cfg_addr,
        .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid, .parity_err_response,
        .link_parity_check_en, .link_msg_end, .link_other_req, .link_yield, .partner_rate_pins,
        .link_rate_captured, .pci_cfg_cycle, .slot_idsel_raw, .slot_idsel, .lan_cfg_decode,
        .lan_cfg_select);
    hub_partner hub (.clock, .arst_n, .want, .gap, .msg_end(link_msg_end),
        .other_req(link_other_req), .rate_pins(partner_rate_pins));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clock);
        {cfg_wr, cfg_addr, cfg_be, cfg_wdata} <= {1'b1, a, be, d};
        @(posedge clock);
        cfg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clock);
        {cfg_rd, cfg_addr} <= {1'b1, a};
        @(posedge clock);
        cfg_rd <= 1'b0;
        @(negedge clock);
        chk({31'h0, cfg_rvalid}, 32'h1);
        chk(cfg_rdata, exp);
    endtask
    task automatic t_regs;
        rd(8'h40, 32'h7620_2802);
        chk({31'h0, link_rate_captured}, 32'h1);
        rd(8'h44, 32'h0000_0000);
        wr(8'h40, 4'hf, 32'hffff_ffff);
        rd(8'h40, 32'h763f_2802);
        wr(8'h40, 4'hb, 32'h0000_0000);
        rd(8'h40, 32'h763f_2802);
        wr(8'h44, 4'hf, 32'hffff_ffff);
        rd(8'h44, 32'h0000_013f);
        wr(8'h48, 4'hf, 32'hffff_ffff);
        rd(8'h48, 32'h0000_0000);
        wr(8'h40, 4'hf, 32'h0000_0000);
        wr(8'h44, 4'hf, 32'h0000_0000);
        $display("test regs done");
    endtask
    task automatic t_parity;
        wr(8'h40, 4'h4, 32'h0010_0000);
        repeat (2) @(negedge clock);
        chk({31'h0, link_parity_check_en}, 32'h0);
        wr(8'h40, 4'h4, 32'h0000_0000);
        repeat (2) @(negedge clock);
        chk({31'h0, link_parity_check_en}, 32'h1);
        @(posedge clock);
        parity_err_response <= 1'b0;
        repeat (2) @(negedge clock);
        chk({31'h0, link_parity_check_en}, 32'h0);
        @(posedge clock);
        parity_err_response <= 1'b1;
        $display("test parity done");
    endtask
    // spacing between two yields with the other master always asking
    task automatic t_slice(input logic [3:0] s, input logic [3:0] g, input int exp);
        int k;
        wr(8'h40, 4'h4, {12'h000, s, 16'h0000});
        gap <= g;
        repeat (12) @(negedge clock);
        k = 0;
        while (link_yield !== 1'b1 && k < 40) begin
            @(negedge clock);
            k++;
        end
        k = 0;
        do begin
            @(negedge clock);
            k++;
        end while (link_yield !== 1'b1 && k < 40);
        chk(32'(k), 32'(exp));
        $display("test slice %0d done", s);
    endtask
    task automatic t_hide;
        for (int n = 0; n < 6; n++) begin
            wr(8'h44, 4'h1, 32'(1 << n));
            pci_cfg_cycle <= 1'b1;
            repeat (2) @(negedge clock);
            chk({26'h0, slot_idsel}, {26'h0, 6'h3f & ~(6'h01 << n)});
            @(posedge clock);
            pci_cfg_cycle <= 1'b0;
        end
        wr(8'h44, 4'h3, 32'h0000_0100);
        pci_cfg_cycle <= 1'b1;
        repeat (2) @(negedge clock);
        chk({31'h0, lan_cfg_select}, 32'h0);
        chk({26'h0, slot_idsel}, 32'h3f);
        wr(8'h44, 4'h2, 32'h0000_0000);
        repeat (2) @(negedge clock);
        chk({31'h0, lan_cfg_select}, 32'h1);
        @(posedge clock);
        {slot_idsel_raw, lan_cfg_decode} <= {6'h15, 1'b0};
        repeat (2) @(negedge clock);
        chk({26'h0, slot_idsel}, 32'h15);
        chk({31'h0, lan_cfg_select}, 32'h0);
        $display("test hide done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", tests_run, fails);
        if (fails == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // a hang costs a mismatch rather than an endless run
    always @(posedge clock) begin
        cycles++;
        if (cycles == 2000) begin
            fails++;
            end_of_test();
        end
    end
    initial begin
        repeat (6) @(posedge clock);
        arst_n <= 1'b1;
        repeat (4) @(posedge clock);
        t_regs();
        t_parity();
        t_slice(4'h0, 4'h0, 1);
        t_slice(4'h0, 4'h3, 4);
        t_slice(4'h1, 4'h0, 5);
        t_slice(4'h2, 4'h0, 9);
        t_hide();
        end_of_test();
    end
endmodule
bind bridge_link_cfg bridge_link_cfg_asserts #(.SLOT_COUNT(SLOT_COUNT)) chk_u (.clock,
    .arst_n, .cfg_wr, .cfg_rd, .cfg_addr, .cfg_be, .cfg_wdata, .cfg_rdata, .cfg_rvalid,
    .parity_err_response, .link_parity_check_en, .link_msg_end, .link_other_req,
    .link_yield, .partner_rate_pins, .link_rate_captured, .pci_cfg_cycle, .slot_idsel_raw,
    .slot_idsel, .lan_cfg_decode, .lan_cfg_select);
`default_nettype wire

// ---- verif/hub_partner.sv ----
/* upstream hub model: other-master request, message ends, rate pins.
   assumes the bench sets want and the message gap on clock rises. */
`default_nettype none
module hub_partner (
    input wire logic clock,
    input wire logic arst_n,
    input wire logic want,
    input wire logic [3:0] gap,
    output logic msg_end,
    output logic other_req,
    output logic [2:0] rate_pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [3:0] n;
    assign rate_pins = 3'h2;
    assign other_req = want;
    // one message end every gap+1 clocks while the link is wanted
    always @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            n <= 4'h0;
            msg_end <= 1'b0;
        end else begin
            n <= (n >= gap) ? 4'h0 : n + 4'h1;
            msg_end <= want && n >= gap;
        end
    end
endmodule
`default_nettype wire
